// File: verilog/vms_pkg.sv
// Constants, types and map for the vector map and stack block.
// Assumes one system clock domain and an AXI4-Lite register master.
package vms_pkg;
  localparam int          SRC_N      = 11;
  localparam int          RAM_BYTES  = 128;
  localparam int          VEC_BYTES  = 34;
  localparam int          AXI_AW     = 18;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BRK    = 16'hfe0b;
  localparam logic [15:0] IDX_LVS    = 16'hfe0c;
  localparam logic [15:0] IDX_FBP    = 16'hff7e;
  localparam logic [15:0] IDX_TRIM   = 16'hffc0;
  localparam logic [15:0] IDX_WDOG   = 16'hffff;
  localparam logic [15:0] IDX_VEC0   = 16'h1000;
  localparam logic [15:0] IDX_ERASE  = 16'h1100;
  localparam logic [15:0] IDX_SP     = 16'h1101;
  localparam logic [15:0] IDX_STAT   = 16'h1102;
  localparam logic [15:0] VEC_BASE   = 16'hffde;
  localparam logic [15:0] RAM_LO     = 16'h0080;
  localparam logic [15:0] RAM_HI     = 16'h00ff;
  localparam logic [15:0] SP_RST     = 16'h00ff;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam logic [2:0]  INT_FRAME  = 3'h5;
  localparam logic [2:0]  CALL_FRAME = 3'h2;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_ERR   = 2'h2;
  localparam logic [3:0]  SRC_RESET  = 4'h0;
  localparam logic [3:0]  SRC_TIM0   = 4'h3;
  // High-byte address of each vector, index 0 ranks highest
  localparam logic [15:0] VEC_ADDR [SRC_N] = '{
    16'hfffe,  // reset
    16'hfffc,  // software_interrupt
    16'hfffa,  // external request
    16'hfff6,  // general_timer channel 0
    16'hfff4,  // general_timer channel 1
    16'hfff2,  // general_timer overflow
    16'hfff0,  // modulator fault
    16'hffee,  // modulator_periodic_interrupt
    16'hffec,  // fine_modulator_shutdown
    16'hffe0,  // keyboard
    16'hffde   // converter complete
  };
  typedef struct packed {
    logic [7:0] ccr;
    logic [7:0] acc;
    logic [7:0] idxLo;
    logic [7:0] pcHi;
    logic [7:0] pcLo;
  } vms_ctx_s;
  typedef enum {ST_IDLE, ST_PUSH, ST_FETCH_HI, ST_FETCH_LO, ST_SERVE} vms_state_e;
endpackage

// File: verilog/vector_map_and_stack.sv
// Vector table, stack engine, RAM window and high-page system registers.
// Assumes core handshakes are synchronous to mclk and an AXI4-Lite master.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Vector priority falls with vector address; reset highest, converter lowest.
// - Timer channel 0 service address comes from its high-then-low vector pair.
// - Timer channel 1 uses its own pair, just below channel 0.
// - Timer overflow uses its own pair, below both timer channels.
// - Modulator fault uses its own pair, directly below timer overflow.
// - Modulator periodic interrupt uses the pair just below the fault vector.
// - Fine modulator shutdown uses its own pair, below periodic interrupt.
// - Addresses 0x0080 through 0x00ff decode to on-chip RAM.
// - Stack pointer is 16 bits, but stack bytes are only kept inside the RAM window.
// - Interrupt entry other than reset pushes five bytes of register state first.
// - Interrupt entry never stacks the upper index register half.
// - A subroutine call pushes a two-byte return address.
// - Stack pointer decrements on each push, increments on each pull.
// - Any write to the watchdog location clears its counter; reset leaves it.
// - Erasing the vector page also erases the oscillator trim byte.
module vector_map_and_stack
  import vms_pkg::*;
#(
  parameter logic [7:0] TRIM_DEF = 8'h80
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic [SRC_N-1:0]  irqReq,
  input  wire logic              intTake,
  input  wire vms_ctx_s          ctx,
  input  wire logic              callReq,
  input  wire logic [15:0]       retAddr,
  input  wire logic              pullReq,
  input  wire logic              spLoad,
  input  wire logic [15:0]       spValue,
  input  wire logic              svcDone,
  input  wire logic              breakEnableBit,
  input  wire logic              breakActiveBit,
  input  wire logic              lowVoltageDetectFlag,
  input  wire logic [7:0]        flashProtect,
  output logic                   busy,
  output logic                   intPending,
  output logic [15:0]            vecTarget,
  output logic                   vecValid,
  output logic [7:0]             pullData,
  output logic                   pullValid,
  output logic                   watchdogClear,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  vms_state_e       state_q;
  logic [2:0]       cnt_q;
  logic             callMode_q;
  logic [39:0]      frame_q;
  logic [3:0]       src_q;
  logic [15:0]      sp_q;
  logic [SRC_N-1:0] pend_q;
  logic [7:0]       hi_q;
  logic [7:0]       ram_q [RAM_BYTES];
  logic [7:0]       vec_q [VEC_BYTES];
  logic [7:0]       trim_q;
  logic             awPend_q;
  logic             wPend_q;
  logic [15:0]      awIdx_q;
  logic [7:0]       wData_q;
  logic             wLane_q;

  // Priority pick: lowest index wins, table order is address order
  function automatic logic [3:0] topOf(input logic [SRC_N-1:0] p);
    logic [3:0] s;
    s = 4'h0;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (p[i]) s = 4'(i);
    end
    return s;
  endfunction

  function automatic logic inRam(input logic [15:0] a);
    return (a >= RAM_LO) && (a <= RAM_HI);
  endfunction

  wire logic       anyPend  = |pend_q;
  wire logic [3:0] topSrc   = topOf(pend_q);
  wire logic       takeInt  = (state_q == ST_IDLE) && intTake && anyPend;
  wire logic       takeCall = (state_q == ST_IDLE) && !takeInt && callReq;
  wire logic       takePull = (state_q == ST_IDLE) && !takeInt && !callReq && pullReq;
  wire logic       takeLoad = (state_q == ST_IDLE) && !takeInt && !callReq && !pullReq && spLoad;
  wire logic [15:0] spInc   = sp_q + 16'h0001;
  wire logic [15:0] spDec   = sp_q - 16'h0001;
  wire logic       pushHit  = (state_q == ST_PUSH) && inRam(sp_q);
  wire logic       pullHit  = inRam(spInc);
  wire logic [6:0] pushIdx  = sp_q[6:0];
  wire logic [6:0] pullIdx  = spInc[6:0];
  wire logic [15:0] vecHiAddr = VEC_ADDR[src_q];
  wire logic [15:0] vecOff    = vecHiAddr - VEC_BASE;
  wire logic [5:0] fetchHi  = vecOff[5:0];
  wire logic [5:0] fetchLo  = fetchHi + 6'h01;
  wire logic       pushLast = (state_q == ST_PUSH) && (cnt_q == 3'h1);
  wire logic [SRC_N-1:0] pendClr = ((state_q == ST_SERVE) && svcDone) ? (SRC_N'(1) << src_q) : '0;

  assign busy       = (state_q != ST_IDLE);
  assign intPending = anyPend;

  // Set wins over the service-done clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) pend_q <= '0;
    else        pend_q <= (pend_q & ~pendClr) | irqReq;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      cnt_q      <= 3'h0;
      callMode_q <= 1'b0;
      frame_q    <= '0;
      src_q      <= SRC_RESET;
      hi_q       <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (takeInt) begin
            src_q      <= topSrc;
            frame_q    <= ctx;
            cnt_q      <= INT_FRAME;
            callMode_q <= 1'b0;
            state_q    <= (topSrc == SRC_RESET) ? ST_FETCH_HI : ST_PUSH;
          end else if (takeCall) begin
            frame_q    <= {24'h0, retAddr};
            cnt_q      <= CALL_FRAME;
            callMode_q <= 1'b1;
            state_q    <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          frame_q <= {8'h00, frame_q[39:8]};
          cnt_q   <= cnt_q - 3'h1;
          if (pushLast) state_q <= callMode_q ? ST_IDLE : ST_FETCH_HI;
        end
        ST_FETCH_HI: begin
          hi_q    <= vec_q[fetchHi];
          state_q <= ST_FETCH_LO;
        end
        ST_FETCH_LO: state_q <= ST_SERVE;
        ST_SERVE: begin
          if (svcDone) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Low byte of the frame goes first: return low, then high, index, acc, ccr
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)                  sp_q <= SP_RST;
    else if (state_q == ST_PUSH) sp_q <= spDec;
    else if (takePull)           sp_q <= spInc;
    else if (takeLoad)           sp_q <= spValue;
  end

  // Stack writes outside the window are dropped
  always_ff @(posedge mclk) begin
    if (pushHit) ram_q[pushIdx] <= frame_q[7:0];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vecTarget <= 16'h0000;
      vecValid  <= 1'b0;
      pullData  <= 8'h00;
      pullValid <= 1'b0;
    end else begin
      vecValid  <= (state_q == ST_FETCH_LO);
      pullValid <= takePull;
      if (state_q == ST_FETCH_LO) vecTarget <= {hi_q, vec_q[fetchLo]};
      if (takePull) pullData <= pullHit ? ram_q[pullIdx] : ERASED;
    end
  end

  // AXI4-Lite write path
  wire logic        doWrite = awPend_q && wPend_q && !s_axi_bvalid;
  wire logic [15:0] vecRel  = awIdx_q - IDX_VEC0;
  // Strobe gates programming only, so a masked vector byte still answers OKAY
  wire logic        vecHitW = (awIdx_q >= IDX_VEC0) && (vecRel < 16'(VEC_BYTES));
  wire logic        wrVec   = doWrite && wLane_q && vecHitW;
  wire logic        wrErase = doWrite && wLane_q && (awIdx_q == IDX_ERASE) && wData_q[0];
  wire logic        wrWdog  = doWrite && (awIdx_q == IDX_WDOG);
  wire logic        wrMap   = vecHitW || (awIdx_q == IDX_ERASE) || (awIdx_q == IDX_WDOG)
                              || (awIdx_q == IDX_BRK) || (awIdx_q == IDX_LVS)
                              || (awIdx_q == IDX_FBP) || (awIdx_q == IDX_TRIM)
                              || (awIdx_q == IDX_SP) || (awIdx_q == IDX_STAT);

  assign s_axi_awready = !awPend_q;
  assign s_axi_wready  = !wPend_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awPend_q     <= 1'b0;
      wPend_q      <= 1'b0;
      awIdx_q      <= 16'h0000;
      wData_q      <= 8'h00;
      wLane_q      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awPend_q <= 1'b1;
        awIdx_q  <= s_axi_awaddr[AXI_AW-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wPend_q <= 1'b1;
        wData_q <= s_axi_wdata[7:0];
        wLane_q <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awPend_q     <= 1'b0;
        wPend_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMap ? RESP_OKAY : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Clearing is a strobe; the counter itself lives in the watchdog unit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) watchdogClear <= 1'b0;
    else        watchdogClear <= wrWdog;
  end

  // Flash-backed bytes; reset restores the erased vector image and TRIM_DEF trim, a trade-off for sim
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trim_q <= TRIM_DEF;
    end else if (wrErase) begin
      trim_q <= ERASED;
    end
  end

  for (genvar k = 0; k < VEC_BYTES; k++) begin : g_vec
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)                                vec_q[k] <= ERASED;
      else if (wrErase)                          vec_q[k] <= ERASED;
      else if (wrVec && (vecRel[5:0] == 6'(k))) vec_q[k] <= wData_q;
    end
  end

  // AXI4-Lite read path
  wire logic [15:0] arIdx  = s_axi_araddr[AXI_AW-1:2];
  wire logic [15:0] arRel  = arIdx - IDX_VEC0;
  wire logic        arVec  = (arIdx >= IDX_VEC0) && (arRel < 16'(VEC_BYTES));
  wire logic [7:0]  brkVal = {breakEnableBit, breakActiveBit, 6'h00};
  wire logic [7:0]  lvsVal = {lowVoltageDetectFlag, 7'h00};
  wire logic [31:0] statVal = {12'h000, 4'(src_q), 5'h00, SRC_N'(pend_q)};
  wire logic        arMap  = arVec || (arIdx == IDX_BRK) || (arIdx == IDX_LVS) || (arIdx == IDX_FBP)
                             || (arIdx == IDX_TRIM) || (arIdx == IDX_WDOG) || (arIdx == IDX_SP)
                             || (arIdx == IDX_STAT) || (arIdx == IDX_ERASE);
  // Watchdog location reads back the low reset-vector byte
  wire logic [31:0] rdMux  = arVec                ? {24'h0, vec_q[arRel[5:0]]}
                           : (arIdx == IDX_BRK)  ? {24'h0, brkVal}
                           : (arIdx == IDX_LVS)  ? {24'h0, lvsVal}
                           : (arIdx == IDX_FBP)  ? {24'h0, flashProtect}
                           : (arIdx == IDX_TRIM) ? {24'h0, trim_q}
                           : (arIdx == IDX_WDOG) ? {24'h0, vec_q[VEC_BYTES-1]}
                           : (arIdx == IDX_SP)   ? {16'h0, sp_q}
                           : (arIdx == IDX_STAT) ? statVal
                           : 32'h0000_0000;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= arMap ? RESP_OKAY : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  sequence intEntry_s;
    takeInt && (topSrc != SRC_RESET);
  endsequence
  sequence intStack_s;
    (state_q == ST_PUSH) [*5] ##1 (state_q == ST_FETCH_HI);
  endsequence
  sequence callStack_s;
    (state_q == ST_PUSH) [*2] ##1 (state_q == ST_IDLE);
  endsequence

  spPushDec_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == ST_PUSH) |=> (sp_q == $past(sp_q) - 16'h0001))
    else $error("stack pointer did not drop on push");
  spPullInc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    takePull |=> (sp_q == $past(sp_q) + 16'h0001) && pullValid)
    else $error("stack pointer did not rise on pull");
  intFrameFive_a: assert property (@(posedge mclk) disable iff (!rst_b)
    intEntry_s |=> intStack_s)
    else $error("interrupt frame is not five bytes");
  callFrameTwo_a: assert property (@(posedge mclk) disable iff (!rst_b)
    takeCall |=> callStack_s)
    else $error("call frame is not two bytes");
  noUpperIndex_a: assert property (@(posedge mclk) disable iff (!rst_b)
    intEntry_s |=> (frame_q == $past(ctx)) ##5 (frame_q == 40'h0))
    else $error("interrupt frame carries extra state");
  vecHighLow_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == ST_FETCH_HI) |=> (hi_q == $past(vec_q[fetchHi])) ##1 vecValid && (vecTarget[15:8] == $past(hi_q)))
    else $error("vector bytes taken in wrong order");
  topPriority_a: assert property (@(posedge mclk) disable iff (!rst_b)
    anyPend |-> ((pend_q & ((SRC_N'(1) << topSrc) - SRC_N'(1))) == '0) && pend_q[topSrc])
    else $error("pick is not the highest pending");
  heldPending_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q inside {ST_FETCH_HI, ST_FETCH_LO, ST_SERVE}) |-> pend_q[src_q])
    else $error("serviced request lost before done");
  timerZeroPair_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == ST_FETCH_HI) && (src_q == SRC_TIM0) |-> (fetchHi == 6'h18))
    else $error("timer channel 0 vector pair wrong");
  ramWindow_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pushHit |-> (sp_q[15:7] == 9'h001))
    else $error("stack write outside RAM window");
  wdogClr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wrWdog |=> watchdogClear ##1 !watchdogClear || $past(wrWdog))
    else $error("watchdog clear strobe wrong");
  eraseTrim_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wrErase |=> (trim_q == ERASED) && (vec_q[0] == ERASED))
    else $error("erase left trim byte intact");

endmodule // vector_map_and_stack

// File: testbench/vms_core_model.sv
// Processor core stand-in: interrupt entry, calls, pulls and stack loads.
// Assumes the block takes a one-cycle request at a rising mclk edge while idle.
`timescale 1ns/1ps
module vms_core_model
  import vms_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   busy,
  input  wire logic   vecValid,
  input  wire logic   pullValid,
  input  wire logic [7:0] pullData,
  output vms_ctx_s    ctx,
  output logic        intTake,
  output logic        callReq,
  output logic [15:0] retAddr,
  output logic        pullReq,
  output logic        spLoad,
  output logic [15:0] spValue,
  output logic        svcDone
);
  initial begin
    {intTake, callReq, pullReq, spLoad, svcDone} = '0;
    ctx     = '0;
    retAddr = '0;
    spValue = '0;
  end
  // Released payload inverted so a stale value never looks live
  task automatic release_req();
    @(posedge mclk);
    {intTake, callReq, pullReq, spLoad} <= '0;
    ctx     <= ~ctx;
    retAddr <= ~retAddr;
    spValue <= ~spValue;
  endtask
  task automatic idle_wait();
    release_req();
    @(posedge mclk);
    while (busy !== 1'b0) @(posedge mclk);
  endtask
  task automatic take(input vms_ctx_s c, output logic [7:0] n);
    @(posedge mclk);
    intTake <= 1'b1;
    ctx     <= c;
    release_req();
    n = 8'h0;
    do begin
      @(posedge mclk);
      n++;
    end while (vecValid !== 1'b1);
  endtask
  task automatic done();
    @(posedge mclk);
    svcDone <= 1'b1;
    @(posedge mclk);
    svcDone <= 1'b0;
  endtask
  task automatic call(input logic [15:0] ra);
    @(posedge mclk);
    callReq <= 1'b1;
    retAddr <= ra;
    idle_wait();
  endtask
  task automatic pull(output logic [7:0] d, output logic ok);
    @(posedge mclk);
    pullReq <= 1'b1;
    release_req();
    @(posedge mclk);
    d  = pullData;
    ok = pullValid;
  endtask
  // Stack kept in RAM except at the window edges (0x0080, 0x00ff) and where a test reads the pointer back only
  task automatic load(input logic [15:0] v);
    @(posedge mclk);
    spLoad  <= 1'b1;
    spValue <= v;
    idle_wait();
  endtask
endmodule // vms_core_model

// File: testbench/vector_map_and_stack_tb.sv
// Self-checking bench for the vector map and stack block.
// Assumes vms_core_model as the core and drives AXI4-Lite itself.
`timescale 1ns/1ps
module vector_map_and_stack_tb;
  import vms_pkg::*;
  localparam logic [7:0] TRIM_TB = 8'h3c;
  localparam int         PRI [3] = '{3, 7, 10};
  typedef struct packed {logic [3:0] src; logic [15:0] hiAddr; logic [15:0] target;} vms_row_s;
  localparam vms_row_s ROWS [SRC_N] = '{
    {4'h0, 16'hfffe, 16'h1aa1}, {4'h1, 16'hfffc, 16'h2bb2}, {4'h2, 16'hfffa, 16'h3cc3},
    {4'h3, 16'hfff6, 16'h4dd4}, {4'h4, 16'hfff4, 16'h5ee5}, {4'h5, 16'hfff2, 16'h6ff6},
    {4'h6, 16'hfff0, 16'h7117}, {4'h7, 16'hffee, 16'h8228}, {4'h8, 16'hffec, 16'h9339},
    {4'h9, 16'hffe0, 16'ha44a}, {4'ha, 16'hffde, 16'hb55b}};
  logic mclk, rst_b, intTake, callReq, pullReq, spLoad, svcDone, busy, intPending;
  logic vecValid, pullValid, watchdogClear, breakEnableBit, breakActiveBit, lowVoltageDetectFlag;
  logic [SRC_N-1:0] irqReq;
  vms_ctx_s ctx, c;
  logic [15:0] retAddr, spValue, vecTarget;
  logic [7:0] pullData, flashProtect, n, pd, wdCount;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pv;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors, numChecks, cycles;
  vector_map_and_stack #(.TRIM_DEF(TRIM_TB)) i_vector_map_and_stack (.mclk, .rst_b, .irqReq, .intTake,
    .ctx, .callReq, .retAddr, .pullReq, .spLoad, .spValue, .svcDone, .breakEnableBit, .breakActiveBit,
    .lowVoltageDetectFlag, .flashProtect, .busy, .intPending, .vecTarget, .vecValid, .pullData, .pullValid,
    .watchdogClear, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  vms_core_model i_vms_core_model (.mclk, .busy, .vecValid, .pullValid, .pullData, .ctx, .intTake,
    .callReq, .retAddr, .pullReq, .spLoad, .spValue, .svcDone);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the several hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (watchdogClear === 1'b1) wdCount <= wdCount + 8'h1;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] dat, output logic [1:0] resp,
                    input logic [3:0] st = 4'hf);
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= dat;
    s_axi_wstrb   <= st;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  task automatic raise(input logic [SRC_N-1:0] m);
    @(posedge mclk);
    irqReq <= m;
    @(posedge mclk);
    irqReq <= '0;
  endtask
  task automatic pl(input logic [7:0] exp);
    i_vms_core_model.pull(pd, pv);
    chk({pv, pd}, {1'b1, exp});
  endtask
  initial begin
    {rst_b, irqReq, breakEnableBit, breakActiveBit, lowVoltageDetectFlag, flashProtect} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wdCount, c} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(IDX_SP, 32'hff);
    rdc(IDX_TRIM, {24'h0, TRIM_TB});
    rdc(16'h0001, 32'h0, RESP_ERR);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      breakActiveBit <= i[1];
      breakEnableBit <= i[0];
      lowVoltageDetectFlag <= i[0];
      flashProtect <= 8'h5a + 8'(i);
      rdc(IDX_BRK, {24'h0, i[0], i[1], 6'h0});
      rdc(IDX_LVS, {24'h0, i[0], 7'h0});
      rdc(IDX_FBP, {24'h0, 8'h5a + 8'(i)});
    end
    foreach (ROWS[k]) begin
      wr(IDX_VEC0 + ROWS[k].hiAddr - 16'hffde, {24'h0, ROWS[k].target[15:8]}, r);
      wr(IDX_VEC0 + ROWS[k].hiAddr - 16'hffdd, {24'h0, ROWS[k].target[7:0]}, r);
      chk(r, RESP_OKAY);
      i_vms_core_model.load(16'h00ff);
      raise(11'h1 << ROWS[k].src);
      i_vms_core_model.take(c, n);
      chk(vecTarget, ROWS[k].target);
      chk(busy, 1'b1);
      chk(n, (ROWS[k].src == 4'h0) ? 8'd3 : 8'd8);
      rdc(IDX_SP, (ROWS[k].src == 4'h0) ? 32'hff : 32'hfa);
      i_vms_core_model.done();
      @(posedge mclk);
      chk(intPending, 1'b0);
      chk(busy, 1'b0);
    end
    raise(11'h488);
    for (int j = 0; j < 3; j++) begin
      i_vms_core_model.load(16'h00ff);
      i_vms_core_model.take(c, n);
      chk(vecTarget, ROWS[PRI[j]].target);
      i_vms_core_model.done();
      @(posedge mclk);
      chk(intPending, j < 2);
    end
    i_vms_core_model.load(16'h00ff);
    raise(11'h010);
    i_vms_core_model.take({8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, n);
    rdc(IDX_STAT, 32'h0004_0010);
    i_vms_core_model.done();
    for (int j = 1; j < 6; j++) pl(8'(17 * j));
    rdc(IDX_SP, 32'hff);
    i_vms_core_model.call(16'h1234);
    rdc(IDX_SP, 32'hfd);
    pl(8'h12);
    pl(8'h34);
    i_vms_core_model.load(16'h0080);
    i_vms_core_model.call(16'habcd);
    pl(8'hff);
    pl(8'hcd);
    i_vms_core_model.load(16'h00ff);
    pl(8'hff);
    i_vms_core_model.load(16'hc000);
    rdc(IDX_SP, 32'hc000);
    wr(IDX_TRIM, 32'h55, r);
    chk(r, RESP_OKAY);
    rdc(IDX_TRIM, {24'h0, TRIM_TB});
    wr(IDX_WDOG, 32'h0, r);
    wr(IDX_WDOG, 32'hff, r);
    repeat (2) @(posedge mclk);
    chk(wdCount, 8'h2);
    rdc(IDX_WDOG, 32'ha1);
    wr(IDX_ERASE, 32'h1, r);
    rdc(IDX_TRIM, 32'hff);
    rdc(IDX_WDOG, 32'hff);
    wr(IDX_VEC0 + 16'h0021, 32'h77, r, 4'he);
    chk(r, RESP_OKAY);
    rdc(IDX_WDOG, 32'hff);
    wr(16'h0001, 32'h0, r);
    chk(r, RESP_ERR);
    // Second reset in mid-run restores pointer and trim
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(IDX_SP, 32'hff);
    rdc(IDX_TRIM, {24'h0, TRIM_TB});
    give_verdict();
  end
endmodule // vector_map_and_stack_tb
